// File: design/uart_holding_and_int_enable.sv
// Host side of a single-channel UART: bank select, holding registers,
// start-bit validation and interrupt enable with its sources.
// Assumes FIFOs, shifter and baud generator sit outside on the same clock.
//
// Notes on behaviour
// - General set only with divisor off, bank 000
// - Clock-select bit writable only with enhanced on
// - Divisor registers selected while line control bit7
// - Enhanced set only at key 0xbf, bank 00
// - Level counters with bank bit0, bits2:1 zero
// - First extra set when bank bits 01
// - Second extra set when bank bits 10
// - Holding write pushes bus byte into transmit fifo
// - Transmit empty flag on fifo empty or load
// - Holding read pops one received character
// - Start bit sampled mid-bit, false starts dropped
// - Clear-to-send rise interrupts when bit7 set
// - Request-to-send rise interrupts when bit6 set
// - Bit5 gates receive Xoff interrupt
// - Bit4 enables sleep mode
// - Bit3 gates modem change interrupt
// - Bit2 gates line error interrupt
// - Bit1 gates transmit ready interrupt
// - Bit0 gates receive ready interrupt
// - Receive status follows trigger level with fifos on and bit0 set
// - Data ready set on push, clear when empty
// - Transmit drain interrupt cleared by status read
`timescale 1ns/1ps
module uart_holding_and_int_enable
   import uart_hold_pkg::*;
(
   // Clock, reset, enable
   input  wire logic       SYS_CLK_I,
   input  wire logic       RST_B_I,
   input  wire logic       CLK_EN_I,
   // Host bus
   input  wire logic [2:0] ADDR_I,
   input  wire logic [7:0] WDATA_I,
   input  wire logic       WR_I,
   input  wire logic       RD_I,
   output logic      [7:0] RDATA_O,
   // Bank control from rest of UART
   input  wire logic [2:0] BANK_SEL_I,
   input  wire logic       ENH_EN_I,
   input  wire logic       FIFO_EN_I,
   // Transmit fifo side
   output logic            TX_PUSH_O,
   output logic      [7:0] TX_DATA_O,
   input  wire logic       TX_EMPTY_I,
   input  wire logic       TX_LOAD_I,
   // Receive fifo side
   output logic            RX_POP_O,
   input  wire logic [7:0] RX_DATA_I,
   input  wire logic       RX_EMPTY_I,
   input  wire logic       RX_PUSH_I,
   input  wire logic       RX_AT_TRIG_I,
   // Line, modem and flow events
   input  wire logic [3:0] LINE_ERR_I,
   input  wire logic [3:0] MODEM_CHG_I,
   input  wire logic       XOFF_RCVD_I,
   input  wire logic       RTS_LEVEL_I,
   // Serial pins and sample tick
   input  wire logic       CTS_PIN_I,
   input  wire logic       RXD_PIN_I,
   input  wire logic       TICK16_I,
   // Results
   output logic            START_OK_O,
   output logic            BANK_DIV_O,
   output logic      [2:0] BANK_O,
   output logic            CLK_SEL_O,
   output logic            SLEEP_EN_O,
   output logic            THR_EMPTY_O,
   output logic            DATA_READY_O,
   output logic            RX_STATUS_O,
   output logic            IRQ_O
);

   // ----------------------------------------------------------------
   // Bank decode function
   // ----------------------------------------------------------------
   function automatic bank_t bank_of(input logic [7:0] lc, input logic [2:0] xb);
      bank_t b;
      b = BANK_GENERAL;
      if (xb[2:1] == XBANK_ONE) begin
         b = BANK_EXTRA1;
      end else if (xb[2:1] == XBANK_TWO) begin
         b = BANK_EXTRA2;
      end else if (xb[2:1] == XBANK_NONE && lc == LCTL_ENH_KEY) begin
         b = BANK_ENHANCE;
      end else if (lc[LCTL_DIV_BIT]) begin
         b = BANK_DIVISOR;
      end else if (xb[0] && xb[2:1] == XBANK_NONE) begin
         b = BANK_LEVELS;
      end
      return b;
   endfunction : bank_of

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] cts_sync_q, cts_sync_d;   // Clear-to-send, two stages
   logic [1:0] rxd_sync_q, rxd_sync_d;   // Receive line, two stages
   logic       cts_last_q, cts_last_d;   // Previous synced level
   logic       rxd_last_q, rxd_last_d;
   logic       rts_last_q, rts_last_d;   // Same-domain, no sync needed

   // Register and flag state
   logic [7:0] lctl_q, lctl_d;           // Line control
   logic [7:0] ien_q, ien_d;             // Interrupt enable
   logic       clk_sel_q, clk_sel_d;     // Modem control clock select
   logic       cts_pend_q, cts_pend_d;   // Sticky edge events
   logic       rts_pend_q, rts_pend_d;
   logic       tx_pend_q, tx_pend_d;     // Transmit drained event
   logic       tx_empty_q, tx_empty_d;   // Previous fifo empty
   logic       thr_empty_q, thr_empty_d;
   logic       ready_q, ready_d;
   logic       rx_stat_q, rx_stat_d;
   logic       irq_q, irq_d;
   logic [7:0] rdata_q, rdata_d;
   logic       push_q, push_d;
   logic [7:0] txd_q, txd_d;
   logic       pop_q, pop_d;
   bank_t      bank_now;
   logic       in_general;
   logic       rx_irq, tx_irq;

   // Start detector state
   rx_state_t  rx_st_q, rx_st_d;
   logic [3:0] tick_cnt_q, tick_cnt_d;
   logic       half_q, half_d;           // Half-tick flag for the .5, held until the next start
   logic       start_ok_q, start_ok_d;

   assign bank_now   = bank_of(lctl_q, BANK_SEL_I);
   assign in_general = (bank_now == BANK_GENERAL) && (BANK_SEL_I == 3'h0);

   // ----------------------------------------------------------------
   // Host register next state
   // ----------------------------------------------------------------
   always_comb begin
      cts_sync_d  = {cts_sync_q[0], CTS_PIN_I};
      rxd_sync_d  = {rxd_sync_q[0], RXD_PIN_I};
      cts_last_d  = cts_sync_q[1];
      rxd_last_d  = rxd_sync_q[1];
      rts_last_d  = RTS_LEVEL_I;
      lctl_d      = lctl_q;
      ien_d       = ien_q;
      clk_sel_d   = clk_sel_q;
      push_d      = 1'b0;
      pop_d       = 1'b0;
      txd_d       = txd_q;
      rdata_d     = rdata_q;
      tx_empty_d  = TX_EMPTY_I;
      // Line control lives in every bank so software can always leave one
      if (WR_I && ADDR_I == ADDR_LCTL) begin
         lctl_d = WDATA_I;
      end
      if (WR_I && in_general) begin
         case (ADDR_I)
            ADDR_HOLD: begin
               push_d = 1'b1;
               txd_d  = WDATA_I;
            end
            ADDR_IEN: begin
               // Upper half only opens with enhanced functions
               ien_d = ENH_EN_I ? WDATA_I : {ien_q[7:4], WDATA_I[3:0]};
            end
            ADDR_MCTL: begin
               if (ENH_EN_I) begin
                  clk_sel_d = WDATA_I[MCTL_CLK_BIT];
               end
            end
            default: begin
            end
         endcase
      end
      // Reads return data one cycle later
      if (RD_I) begin
         case (ADDR_I)
            ADDR_HOLD:  rdata_d = in_general ? RX_DATA_I : 8'h00;
            ADDR_IEN:   rdata_d = in_general ? ien_q : 8'h00;
            ADDR_SRC:   rdata_d = {6'h00, rx_stat_q, tx_pend_q};
            ADDR_LCTL:  rdata_d = lctl_q;
            ADDR_LSTAT: rdata_d = {2'h0, thr_empty_q, LINE_ERR_I, ready_q};
            ADDR_MSTAT: rdata_d = {4'h0, MODEM_CHG_I};
            default:    rdata_d = 8'h00;
         endcase
         if (ADDR_I == ADDR_HOLD && in_general && !RX_EMPTY_I) begin
            pop_d = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Flags and interrupt next state
   // ----------------------------------------------------------------
   always_comb begin
      cts_pend_d  = cts_pend_q;
      rts_pend_d  = rts_pend_q;
      tx_pend_d   = tx_pend_q;
      // Clears first so that a same-cycle event wins
      if (RD_I && ADDR_I == ADDR_SRC) begin
         tx_pend_d  = 1'b0;
         cts_pend_d = 1'b0;
         rts_pend_d = 1'b0;
      end
      if (WR_I && in_general && ADDR_I == ADDR_HOLD) begin
         tx_pend_d = 1'b0;
      end
      if (cts_sync_q[1] && !cts_last_q) begin
         cts_pend_d = 1'b1;
      end
      if (RTS_LEVEL_I && !rts_last_q) begin
         rts_pend_d = 1'b1;
      end
      if (TX_EMPTY_I && !tx_empty_q) begin
         tx_pend_d = 1'b1;
      end
      thr_empty_d = TX_EMPTY_I || TX_LOAD_I;
      if (RX_PUSH_I) begin
         ready_d = 1'b1;
      end else begin
         ready_d = !RX_EMPTY_I;
      end
      rx_stat_d = FIFO_EN_I && ien_q[IEN_RECEIVE_READY_IRQ] && RX_AT_TRIG_I;
      // Receive ready: trigger level with fifos, any data without
      rx_irq = FIFO_EN_I ? RX_AT_TRIG_I : !RX_EMPTY_I;
      tx_irq = FIFO_EN_I ? tx_pend_q : thr_empty_q;
      irq_d  = (ien_q[IEN_CTS]   && cts_pend_q)
            || (ien_q[IEN_RTS]   && rts_pend_q)
            || (ien_q[IEN_XOFF]  && XOFF_RCVD_I)
            || (ien_q[IEN_MODEM] && |MODEM_CHG_I)
            || (ien_q[IEN_LINE]  && |LINE_ERR_I)
            || (ien_q[IEN_TRANSMIT_READY_IRQ] && tx_irq)
            || (ien_q[IEN_RECEIVE_READY_IRQ] && rx_irq);
   end

   // ----------------------------------------------------------------
   // Start bit validation next state
   // ----------------------------------------------------------------
   always_comb begin
      rx_st_d    = rx_st_q;
      tick_cnt_d = tick_cnt_q;
      half_d     = half_q;
      start_ok_d = 1'b0;
      case (rx_st_q)
         RX_IDLE: begin
            // Falling edge of the line starts the count
            if (!rxd_sync_q[1] && rxd_last_q) begin
               rx_st_d    = RX_HUNT;
               tick_cnt_d = 4'h0;
               half_d     = 1'b0;
            end
         end
         RX_HUNT: begin
            if (TICK16_I) begin
               tick_cnt_d = tick_cnt_q + 4'h1;
               if (tick_cnt_d == START_MID_TICKS) begin
                  // Seventh tick seen; the half tick is one clock later
                  half_d = 1'b1;
               end
            end
            if (half_q) begin
               // Still low mid-bit: real start, else false start
               start_ok_d = !rxd_sync_q[1];
               rx_st_d    = rxd_sync_q[1] ? RX_IDLE : RX_VALID;
            end
         end
         RX_VALID: begin
            // Wait for line to return high before hunting again
            if (rxd_sync_q[1]) begin
               rx_st_d = RX_IDLE;
            end
         end
         default: rx_st_d = RX_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // All registers, frozen while clock enable is low
   // ----------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         cts_sync_q  <= 2'h0;
         rxd_sync_q  <= 2'h3;
         cts_last_q  <= 1'b0;
         rxd_last_q  <= 1'b1;
         rts_last_q  <= 1'b0;
         lctl_q      <= LCTL_RESET;
         ien_q       <= IEN_RESET;
         clk_sel_q   <= 1'b0;
         cts_pend_q  <= 1'b0;
         rts_pend_q  <= 1'b0;
         tx_pend_q   <= 1'b0;
         tx_empty_q  <= 1'b1;
         thr_empty_q <= 1'b1;
         ready_q     <= 1'b0;
         rx_stat_q   <= 1'b0;
         irq_q       <= 1'b0;
         rdata_q     <= 8'h00;
         push_q      <= 1'b0;
         txd_q       <= 8'h00;
         pop_q       <= 1'b0;
         rx_st_q     <= RX_IDLE;
         tick_cnt_q  <= 4'h0;
         half_q      <= 1'b0;
         start_ok_q  <= 1'b0;
      end else if (CLK_EN_I) begin
         cts_sync_q  <= cts_sync_d;
         rxd_sync_q  <= rxd_sync_d;
         cts_last_q  <= cts_last_d;
         rxd_last_q  <= rxd_last_d;
         rts_last_q  <= rts_last_d;
         lctl_q      <= lctl_d;
         ien_q       <= ien_d;
         clk_sel_q   <= clk_sel_d;
         cts_pend_q  <= cts_pend_d;
         rts_pend_q  <= rts_pend_d;
         tx_pend_q   <= tx_pend_d;
         tx_empty_q  <= tx_empty_d;
         thr_empty_q <= thr_empty_d;
         ready_q     <= ready_d;
         rx_stat_q   <= rx_stat_d;
         irq_q       <= irq_d;
         rdata_q     <= rdata_d;
         push_q      <= push_d;
         txd_q       <= txd_d;
         pop_q       <= pop_d;
         rx_st_q     <= rx_st_d;
         tick_cnt_q  <= tick_cnt_d;
         half_q      <= half_d;
         start_ok_q  <= start_ok_d;
      end
   end

   // Bank view registered for the outputs
   logic [2:0] bank_q;
   logic       div_q;
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         bank_q <= 3'h0;
         div_q  <= 1'b0;
      end else if (CLK_EN_I) begin
         bank_q <= bank_now;
         div_q  <= lctl_d[LCTL_DIV_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ----------------------------------------------------------------
   assign RDATA_O      = rdata_q;
   assign TX_PUSH_O    = push_q;
   assign TX_DATA_O    = txd_q;
   assign RX_POP_O     = pop_q;
   assign START_OK_O   = start_ok_q;
   assign BANK_DIV_O   = div_q;
   assign BANK_O       = bank_q;
   assign CLK_SEL_O    = clk_sel_q;
   assign SLEEP_EN_O   = ien_q[IEN_SLEEP];
   assign THR_EMPTY_O  = thr_empty_q;
   assign DATA_READY_O = ready_q;
   assign RX_STATUS_O  = rx_stat_q;
   assign IRQ_O        = irq_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_hold_write;
      CLK_EN_I && WR_I && in_general && ADDR_I == ADDR_HOLD;
   endsequence

   a_hold_push: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      s_hold_write |=> TX_PUSH_O && TX_DATA_O == $past(WDATA_I))
      else $error("holding write did not push");

   a_hold_pop: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && RD_I && in_general && ADDR_I == ADDR_HOLD && !RX_EMPTY_I |=> RX_POP_O)
      else $error("holding read did not pop");

   a_no_push_other: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && !(WR_I && in_general && ADDR_I == ADDR_HOLD) |=> !TX_PUSH_O)
      else $error("push outside general bank");

   a_thr_empty: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && (TX_EMPTY_I || TX_LOAD_I) |=> THR_EMPTY_O)
      else $error("transmit empty flag missed");

   a_ready_push: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && RX_PUSH_I |=> DATA_READY_O)
      else $error("data ready not set on push");

   a_cts_irq: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && cts_pend_q && ien_q[IEN_CTS] |=> IRQ_O)
      else $error("cts interrupt missing");

   a_line_irq: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && ien_q[IEN_LINE] && |LINE_ERR_I |=> IRQ_O)
      else $error("line status interrupt missing");

   a_irq_quiet: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && ien_q == 8'h00 |=> !IRQ_O)
      else $error("interrupt with nothing enabled");

   a_start_false: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && rx_st_q == RX_HUNT && half_q && rxd_sync_q[1] |=> !START_OK_O)
      else $error("false start accepted");

endmodule : uart_holding_and_int_enable

// File: design/uart_hold_pkg.sv
// Constants shared by the UART holding and interrupt-enable block.
// Assumes a single 250 MHz clock domain and an 8-bit host bus with a 3-bit address.
package uart_hold_pkg;

   // --------------------------------------------------------------
   // Host bus register addresses (3-bit)
   // --------------------------------------------------------------
   localparam logic [2:0] ADDR_HOLD    = 3'h0;   // Transmit / receive holding
   localparam logic [2:0] ADDR_IEN     = 3'h1;   // Interrupt enable
   localparam logic [2:0] ADDR_SRC     = 3'h2;   // Interrupt source status (read)
   localparam logic [2:0] ADDR_FCTL    = 3'h2;   // Fifo control (write)
   localparam logic [2:0] ADDR_LCTL    = 3'h3;   // Line control
   localparam logic [2:0] ADDR_MCTL    = 3'h4;   // Modem control, clock select
   localparam logic [2:0] ADDR_LSTAT   = 3'h5;   // Line state flags
   localparam logic [2:0] ADDR_MSTAT   = 3'h6;   // Modem change flags

   // --------------------------------------------------------------
   // Bank selection values and field positions
   // --------------------------------------------------------------
   localparam logic [7:0] LCTL_ENH_KEY = 8'hbf;  // Opens enhanced bank
   localparam int         LCTL_DIV_BIT = 7;      // Divisor latch select
   localparam int         EFC_ENH_BIT  = 4;      // Enhanced functions enable
   localparam int         MCTL_CLK_BIT = 7;      // Clock select in modem control
   localparam logic [1:0] XBANK_NONE   = 2'h0;   // Extra bank bits 2:1 = 00
   localparam logic [1:0] XBANK_ONE    = 2'h1;   // First extra set
   localparam logic [1:0] XBANK_TWO    = 2'h2;   // Second extra set

   // --------------------------------------------------------------
   // Interrupt enable bit positions and reset values
   // --------------------------------------------------------------
   localparam int IEN_RECEIVE_READY_IRQ = 0;
   localparam int IEN_TRANSMIT_READY_IRQ = 1;
   localparam int IEN_LINE  = 2;
   localparam int IEN_MODEM = 3;
   localparam int IEN_SLEEP = 4;
   localparam int IEN_XOFF  = 5;
   localparam int IEN_RTS   = 6;
   localparam int IEN_CTS   = 7;
   localparam logic [7:0] IEN_RESET  = 8'h00;
   localparam logic [7:0] LCTL_RESET = 8'h1d;

   // --------------------------------------------------------------
   // Start bit validation timing (16x sample clock ticks)
   // --------------------------------------------------------------
   localparam logic [3:0] START_MID_TICKS = 4'h7; // Sample after 7.5 ticks

   // Bank decode result
   typedef enum logic [2:0] {
      BANK_GENERAL = 3'b000,
      BANK_DIVISOR = 3'b001,
      BANK_ENHANCE = 3'b010,
      BANK_LEVELS  = 3'b011,
      BANK_EXTRA1  = 3'b100,
      BANK_EXTRA2  = 3'b101
   } bank_t;

   // Receiver start detector states
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_HUNT  = 2'b01,
      RX_VALID = 2'b10
   } rx_state_t;

endpackage : uart_hold_pkg

// File: testbench/uart_far_model.sv
// Far-side model: transmit and receive fifos beside the holding block.
// Assumes the block's clock and its active-low asynchronous reset.
`timescale 1ns/1ps
module uart_far_model #(
   parameter int DRAIN_CYC = 20    // Cycles before the shifter takes a char
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Transmit fifo
   input  wire logic       tx_push_i,
   input  wire logic [7:0] tx_data_i,
   output logic            tx_empty_o,
   output logic            tx_load_o,
   output logic      [7:0] last_tx_o,
   // Receive fifo
   input  wire logic       rx_pop_i,
   output logic      [7:0] rx_data_o,
   output logic            rx_empty_o,
   output logic            rx_push_o = 1'b0
);
   logic [7:0] rxm[4];             // Characters waiting for the host
   logic [7:0] in_byte = 8'h00;    // Character being loaded
   logic [7:0] last_rd;            // Last popped, inverted when empty
   logic [2:0] wp, rp;             // Receive write and read pointers
   int         txn, dly;           // Transmit fill and drain timer
   // Fifo bookkeeping; a slow shifter keeps the empty flag low a while
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         txn <= 0;
         dly <= 0;
         tx_load_o <= 1'b0;
         last_tx_o <= 8'h00;
         last_rd <= 8'h00;
         wp <= 3'h0;
         rp <= 3'h0;
      end else begin
         tx_load_o <= 1'b0;
         if (tx_push_i) begin
            txn <= txn + 1;
            last_tx_o <= tx_data_i;
         end else if (txn > 0 && dly == DRAIN_CYC) begin
            txn <= txn - 1;
            tx_load_o <= 1'b1;
         end
         dly <= (txn > 0 && dly < DRAIN_CYC) ? dly + 1 : 0;
         if (rx_push_o) begin
            rxm[wp[1:0]] <= in_byte;
            wp <= wp + 3'h1;
         end
         if (rx_pop_i && wp != rp) begin
            last_rd <= rxm[rp[1:0]];
            rp <= rp + 3'h1;
         end
      end
   end
   // Head of queue; a stale value never shows once empty
   always_comb begin
      tx_empty_o = (txn == 0);
      rx_empty_o = (wp == rp);
      rx_data_o = rx_empty_o ? ~last_rd : rxm[rp[1:0]];
   end
   // One received character enters the fifo; back-to-back calls leave a gap
   task automatic load(input logic [7:0] d);
      @(negedge clk_i);
      in_byte = d;
      rx_push_o = 1'b1;
      @(negedge clk_i);
      rx_push_o = 1'b0;
   endtask : load
endmodule : uart_far_model

// File: testbench/uart_holding_and_int_enable_bench.sv
// Bench for the UART holding and interrupt-enable block.
// Assumes one 250 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module uart_holding_and_int_enable_bench
   import uart_hold_pkg::*;
;
   logic       clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, enh = 1'b0, fifo_en = 1'b1;
   logic       at_trig = 1'b0, xoff = 1'b0, cts = 1'b0, rxd = 1'b1, tick = 1'b0, rts = 1'b0;
   logic [2:0] addr = 3'h0, bank_sel = 3'h0, bank;
   logic [3:0] line_err = 4'h0, modem = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, tx_data, rx_data, last_tx, v, exp_tx;
   logic       tx_push, tx_empty, tx_load, rx_pop, rx_empty, rx_push, start_ok;
   logic       bank_div, clk_sel, sleep_en, thr_empty, data_ready, rx_status, irq;
   int         error_cnt = 0, total_checks = 0, cyc_cnt = 0, starts = 0, i;
   logic [7:0] lc_t[6] = '{8'h1d, 8'h80, 8'hbf, 8'h1d, 8'h1d, 8'h1d};
   logic [2:0] bs_t[6] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h4};
   bank_t      bk_t[6] = '{BANK_GENERAL, BANK_DIVISOR, BANK_ENHANCE, BANK_LEVELS,
                           BANK_EXTRA1, BANK_EXTRA2};
   logic [7:0] en_t[4] = '{8'h01, 8'h04, 8'h08, 8'h20};
   always #2 clk = ~clk;
   // Sample tick every fourth cycle, start pulses counted, hang ceiling
   always @(negedge clk) tick <= (cyc_cnt % 4 == 0);
   always @(posedge clk) begin
      cyc_cnt++;
      if (start_ok === 1'b1) starts++;
      if (cyc_cnt == 3000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   uart_holding_and_int_enable DUT (.SYS_CLK_I(clk), .RST_B_I(rst_b), .CLK_EN_I(1'b1),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .BANK_SEL_I(bank_sel), .ENH_EN_I(enh), .FIFO_EN_I(fifo_en), .TX_PUSH_O(tx_push),
      .TX_DATA_O(tx_data), .TX_EMPTY_I(tx_empty), .TX_LOAD_I(tx_load), .RX_POP_O(rx_pop),
      .RX_DATA_I(rx_data), .RX_EMPTY_I(rx_empty), .RX_PUSH_I(rx_push),
      .RX_AT_TRIG_I(at_trig), .LINE_ERR_I(line_err), .MODEM_CHG_I(modem),
      .XOFF_RCVD_I(xoff), .RTS_LEVEL_I(rts), .CTS_PIN_I(cts), .RXD_PIN_I(rxd),
      .TICK16_I(tick), .START_OK_O(start_ok), .BANK_DIV_O(bank_div), .BANK_O(bank),
      .CLK_SEL_O(clk_sel), .SLEEP_EN_O(sleep_en), .THR_EMPTY_O(thr_empty),
      .DATA_READY_O(data_ready), .RX_STATUS_O(rx_status), .IRQ_O(irq));
   uart_far_model #(.DRAIN_CYC(20)) far (.clk_i(clk), .rst_b_i(rst_b),
      .tx_push_i(tx_push), .tx_data_i(tx_data), .tx_empty_o(tx_empty),
      .tx_load_o(tx_load), .last_tx_o(last_tx), .rx_pop_i(rx_pop),
      .rx_data_o(rx_data), .rx_empty_o(rx_empty), .rx_push_o(rx_push));
   // ----------------------------------------
   // Host bus cycles and comparison
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd_reg
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      chk("thr_empty", {7'h0, thr_empty}, 8'h01);
      rd_reg(ADDR_IEN, v);
      chk("ien_reset", v, IEN_RESET);
      exp_tx = 8'h00;
      for (i = 0; i < 6; i++) begin
         bank_sel = bs_t[i];
         wr_reg(ADDR_LCTL, lc_t[i]);
         wr_reg(ADDR_HOLD, 8'h10 + i[7:0]);
         cyc(2);
         if (i == 0) exp_tx = 8'h10;
         chk("bank", {5'h0, bank}, {5'h0, bk_t[i]});
         chk("tx_byte", last_tx, exp_tx);
         if (i != 2) chk("bank_div", {7'h0, bank_div}, {7'h0, lc_t[i][7]});
      end
      bank_sel = 3'h0;
      wr_reg(ADDR_LCTL, LCTL_RESET);
      $display("bank test done");
      for (i = 0; i < 2; i++) begin
         enh = i[0];
         wr_reg(ADDR_MCTL, 8'h80);
         wr_reg(ADDR_IEN, 8'hf0);
         rd_reg(ADDR_IEN, v);
         chk("clk_sel", {7'h0, clk_sel}, {7'h0, i[0]});
         chk("ien", v, i[0] ? 8'hf0 : 8'h00);
         chk("sleep", {7'h0, sleep_en}, {7'h0, i[0]});
      end
      $display("enable test done");
      for (i = 0; i < 4; i++) begin
         wr_reg(ADDR_IEN, 8'h00);
         {xoff, modem, line_err, at_trig} = {i == 3, 3'h0, i == 2, i == 1, 3'h0, i == 0};
         cyc(3);
         chk("irq_masked", {7'h0, irq}, 8'h00);
         wr_reg(ADDR_IEN, en_t[i]);
         cyc(3);
         chk("irq_src", {7'h0, irq}, 8'h01);
         if (i == 0) chk("rx_status", {7'h0, rx_status}, 8'h01);
         {xoff, modem, line_err, at_trig} = 10'h000;
         cyc(3);
         chk("irq_gone", {7'h0, irq}, 8'h00);
      end
      // Clear-to-send rise first, then request-to-send rise
      for (i = 0; i < 2; i++) begin
         wr_reg(ADDR_IEN, i[0] ? 8'h40 : 8'h80);
         {rts, cts} = i[0] ? 2'h2 : 2'h1;
         cyc(6);
         chk("irq_edge", {7'h0, irq}, 8'h01);
         rd_reg(ADDR_SRC, v);
         {rts, cts} = 2'h0;
         cyc(6);
         chk("irq_edge_clr", {7'h0, irq}, 8'h00);
      end
      // Status read above cleared the drain event; each drain raises it anew
      wr_reg(ADDR_IEN, 8'h02);
      for (i = 0; i < 2; i++) begin
         wr_reg(ADDR_HOLD, 8'h5a + i[7:0]);
         cyc(2);
         chk("irq_tx_clr", {7'h0, irq}, 8'h00);
         chk("thr_full", {7'h0, thr_empty}, 8'h00);
         chk("tx_byte2", last_tx, 8'h5a + i[7:0]);
         cyc(30);
         chk("thr_drain", {7'h0, thr_empty}, 8'h01);
         chk("irq_drain", {7'h0, irq}, 8'h01);
      end
      rd_reg(ADDR_SRC, v);
      chk("src_drain", v, 8'h01);
      chk("irq_tx", {7'h0, irq}, 8'h00);
      wr_reg(ADDR_IEN, 8'h00);
      $display("interrupt test done");
      far.load(8'h3c);
      far.load(8'hc3);
      cyc(2);
      chk("ready", {7'h0, data_ready}, 8'h01);
      // Without fifos any held character raises receive ready
      fifo_en = 1'b0;
      wr_reg(ADDR_IEN, 8'h01);
      cyc(3);
      chk("irq_rx_nofifo", {7'h0, irq}, 8'h01);
      wr_reg(ADDR_IEN, 8'h00);
      fifo_en = 1'b1;
      rd_reg(ADDR_LSTAT, v);
      chk("line_flags", v, 8'h21);
      rd_reg(ADDR_HOLD, v);
      chk("rx_first", v, 8'h3c);
      rd_reg(ADDR_HOLD, v);
      chk("rx_second", v, 8'hc3);
      cyc(2);
      chk("ready_clr", {7'h0, data_ready}, 8'h00);
      $display("receive test done");
      rxd = 1'b0;
      cyc(8);
      rxd = 1'b1;
      cyc(60);
      chk("false_start", starts[7:0], 8'h00);
      rxd = 1'b0;
      cyc(60);
      chk("true_start", starts[7:0], 8'h01);
      rxd = 1'b1;
      $display("start test done");
      report_and_stop();
   end
endmodule : uart_holding_and_int_enable_bench
